// ==== core/rsl_pkg.sv ====
// Package with register map, timing constants and scan phases for the scan latch block
package rsl_pkg;
   // ****************************************
   // Register byte offsets
   // ****************************************
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
   localparam logic [7:0] ADDR_SCAN_CUR = 8'h10;
   localparam logic [7:0] ADDR_SCAN_MAX = 8'h14;
   localparam logic [7:0] ADDR_WDT_LIMIT = 8'h18;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_RST_CONN_BIT = 1;
   localparam int CTRL_MAX_CLR_BIT = 2;
   localparam int IRQ_SCAN_DONE_BIT = 0;
   localparam int IRQ_WDT_BIT = 1;
   localparam int IRQ_OUT_RISE_BIT = 2;
   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [2:0] CTRL_RESET = 3'h0;
   localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
   localparam logic [31:0] WDT_LIMIT_RESET = 32'h0001_0000;
   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_PS = 8000;
   localparam int END_PROC_MIN_US = 1000;
   localparam int END_PROC_CYCLES = (END_PROC_MIN_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int EVAL_STEPS = 3;
   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;
   typedef enum logic [2:0] {RSL_IDLE, RSL_INPUT, RSL_EVAL, RSL_CHECK, RSL_END} rsl_phase_t;
endpackage

// ==== core/rsl_scan_latch.sv ====
// Scan-cycle framework with a reset-dominant set/reset latch and AXI4-Lite registers
`timescale 1ns/100ps
// Overview of operation
// R1: Set alone drives output high
// R2: Reset asserted drives output low
// R3: Both asserted: reset wins, output low
// R4: Neither asserted: output keeps previous value
// R5: Unconnected reset reads as deasserted
// R6: Output stays high after set drops
// R7: Reset released with set held: high
// R8: Repeat input, evaluate, check while running
// R9: Store each scan duration as current
// R10: Keep largest scan duration seen
// R11: Evaluate blocks in order from inputs
// R12: Overrun of watchdog limit flags, resets
// R13: End-of-scan housekeeping lasts one millisecond minimum
// R14: Latch updates once per scan only
module rsl_scan_latch #(
   parameter int END_CYCLES = rsl_pkg::END_PROC_CYCLES
)(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic set_in,
   input wire logic reset_in,
   output logic latch_out,
   output logic scan_done,
   output logic wdt_error,
   output logic irq,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // ****************************************
   // Input synchronisers
   // ****************************************
   logic [2:0] set_sync, rst_sync;
   logic set_q, rst_q;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         set_sync <= 3'h0;
         rst_sync <= 3'h0;
         set_q <= 1'b0;
         rst_q <= 1'b0;
      end
      else
      begin
         set_sync <= {set_sync[1:0], set_in};
         rst_sync <= {rst_sync[1:0], reset_in};
         if (set_sync[1] == set_sync[2])
            set_q <= set_sync[2];
         if (rst_sync[1] == rst_sync[2])
            rst_q <= rst_sync[2];
      end
   end
   // ****************************************
   // Registers
   // ****************************************
   logic [2:0] ctrl, irq_stat, irq_mask;
   logic [31:0] wdt_limit, scan_cur, scan_max, scan_cnt, end_cnt;
   logic [1:0] eval_idx;
   logic set_snap, rst_snap, eval_set, eval_rst, wdt_hit, out_rise;
   rsl_pkg::rsl_phase_t phase;
   // AXI write path: address and data latched in either order
   logic aw_held, w_held, wr_fire;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   assign wr_fire = aw_held && w_held && !s_axi_bvalid;
   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a <= rsl_pkg::ADDR_WDT_LIMIT) && (a[1:0] == 2'h0);
   endfunction
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= rsl_pkg::AXI_OKAY;
      end
      else
      begin
         s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_fire)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= addr_ok(aw_addr) ? rsl_pkg::AXI_OKAY : rsl_pkg::AXI_SLVERR;
            aw_held <= 1'b0;
            w_held <= 1'b0;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end
   // Control, mask and watchdog limit; byte lane 0 carries narrow fields
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl <= rsl_pkg::CTRL_RESET;
         irq_mask <= rsl_pkg::IRQ_MASK_RESET;
         wdt_limit <= rsl_pkg::WDT_LIMIT_RESET;
      end
      else
      begin
         if (wr_fire && aw_addr == rsl_pkg::ADDR_CTRL && w_strb[0])
            ctrl <= w_data[2:0];
         else
            ctrl[rsl_pkg::CTRL_MAX_CLR_BIT] <= 1'b0;
         if (wr_fire && aw_addr == rsl_pkg::ADDR_IRQ_MASK && w_strb[0])
            irq_mask <= w_data[2:0];
         if (wr_fire && aw_addr == rsl_pkg::ADDR_WDT_LIMIT)
         begin
            for (int i = 0; i < 4; i++)
            begin
               if (w_strb[i])
                  wdt_limit[i*8 +: 8] <= w_data[i*8 +: 8];
            end
         end
      end
   end
   // Sticky status; a new event wins over a write-one clear
   logic [2:0] evt, w1c;
   assign evt = {out_rise, wdt_hit, scan_done};
   assign w1c = (wr_fire && aw_addr == rsl_pkg::ADDR_IRQ_STAT && w_strb[0]) ? w_data[2:0] : 3'h0;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         irq_stat <= 3'h0;
         irq <= 1'b0;
      end
      else
      begin
         irq_stat <= (irq_stat & ~w1c) | evt;
         irq <= |(((irq_stat & ~w1c) | evt) & irq_mask);
      end
   end
   // Read path
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= rsl_pkg::AXI_OKAY;
      end
      else
      begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= addr_ok(s_axi_araddr) ? rsl_pkg::AXI_OKAY : rsl_pkg::AXI_SLVERR;
            unique case (s_axi_araddr)
               rsl_pkg::ADDR_CTRL: s_axi_rdata <= {29'h0, ctrl};
               rsl_pkg::ADDR_STATUS: s_axi_rdata <= {27'h0, phase, wdt_error, latch_out};
               rsl_pkg::ADDR_IRQ_STAT: s_axi_rdata <= {29'h0, irq_stat};
               rsl_pkg::ADDR_IRQ_MASK: s_axi_rdata <= {29'h0, irq_mask};
               rsl_pkg::ADDR_SCAN_CUR: s_axi_rdata <= scan_cur;
               rsl_pkg::ADDR_SCAN_MAX: s_axi_rdata <= scan_max;
               rsl_pkg::ADDR_WDT_LIMIT: s_axi_rdata <= wdt_limit;
               default: s_axi_rdata <= 32'h0000_0000;
            endcase
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end
   // ****************************************
   // Scan sequencer
   // ****************************************
   // Watchdog overrun acts as a system reset of scan state and latch
   assign wdt_hit = (phase != rsl_pkg::RSL_IDLE) && (scan_cnt >= wdt_limit); // R12
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         phase <= rsl_pkg::RSL_IDLE;
         scan_cnt <= 32'h0000_0000;
         end_cnt <= 32'h0000_0000;
         eval_idx <= 2'h0;
         set_snap <= 1'b0;
         rst_snap <= 1'b0;
         eval_set <= 1'b0;
         eval_rst <= 1'b0;
         scan_done <= 1'b0;
         wdt_error <= 1'b0;
      end
      else
      begin
         scan_done <= 1'b0;
         if (wdt_hit)
         begin
            phase <= rsl_pkg::RSL_IDLE; // R12
            wdt_error <= 1'b1; // R12
            scan_cnt <= 32'h0000_0000;
         end
         else
         begin
            if (phase != rsl_pkg::RSL_IDLE)
               scan_cnt <= scan_cnt + 32'h0000_0001;
            unique case (phase)
               rsl_pkg::RSL_IDLE:
               begin
                  scan_cnt <= 32'h0000_0000;
                  if (ctrl[rsl_pkg::CTRL_RUN_BIT])
                  begin
                     phase <= rsl_pkg::RSL_INPUT;
                     wdt_error <= 1'b0;
                  end
               end
               rsl_pkg::RSL_INPUT:
               begin
                  // Inputs frozen for the whole scan
                  set_snap <= set_q; // R8
                  rst_snap <= rst_q && ctrl[rsl_pkg::CTRL_RST_CONN_BIT]; // R5
                  eval_idx <= 2'h0;
                  phase <= rsl_pkg::RSL_EVAL;
               end
               rsl_pkg::RSL_EVAL:
               begin
                  // Input stage, then gating stage, in fixed order
                  unique case (eval_idx)
                     2'h0: eval_set <= set_snap; // R11
                     2'h1: eval_rst <= rst_snap; // R11
                     default: ;
                  endcase
                  eval_idx <= eval_idx + 2'h1;
                  if (eval_idx == 2'(rsl_pkg::EVAL_STEPS - 1))
                     phase <= rsl_pkg::RSL_CHECK;
               end
               rsl_pkg::RSL_CHECK:
               begin
                  end_cnt <= 32'h0000_0000;
                  phase <= rsl_pkg::RSL_END; // R8
               end
               rsl_pkg::RSL_END:
               begin
                  end_cnt <= end_cnt + 32'h0000_0001;
                  if (end_cnt >= 32'(END_CYCLES - 1)) // R13
                  begin
                     scan_done <= 1'b1;
                     // Each scan timed from zero, else the watchdog sees the whole run
                     scan_cnt <= 32'h0000_0000; // R9 R12
                     phase <= ctrl[rsl_pkg::CTRL_RUN_BIT] ? rsl_pkg::RSL_INPUT : rsl_pkg::RSL_IDLE; // R8
                  end
               end
            endcase
         end
      end
   end
   // ****************************************
   // Scan time capture
   // ****************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         scan_cur <= 32'h0000_0000;
         scan_max <= 32'h0000_0000;
      end
      else
      begin
         if (phase == rsl_pkg::RSL_END && end_cnt >= 32'(END_CYCLES - 1))
         begin
            scan_cur <= scan_cnt + 32'h0000_0001; // R9
            if (scan_cnt + 32'h0000_0001 > scan_max || ctrl[rsl_pkg::CTRL_MAX_CLR_BIT])
               scan_max <= scan_cnt + 32'h0000_0001; // R10
         end
         else if (ctrl[rsl_pkg::CTRL_MAX_CLR_BIT])
            scan_max <= 32'h0000_0000;
      end
   end
   // ****************************************
   // Reset-dominant latch
   // ****************************************
   // Updated only at the check phase, once per scan; a watchdog overrun clears it in any phase
   always_ff @(posedge aclk)
   begin
      if (!aresetn || wdt_hit)
      begin
         latch_out <= 1'b0;
         out_rise <= 1'b0;
      end
      else
      begin
         out_rise <= 1'b0;
         if (phase == rsl_pkg::RSL_CHECK) // R14
         begin
            if (eval_rst)
               latch_out <= 1'b0; // R2 R3
            else if (eval_set)
            begin
               latch_out <= 1'b1; // R1 R7
               out_rise <= !latch_out;
            end
            // Neither: holds R4 R6
         end
      end
   end
   // ****************************************
   // Assertions
   // ****************************************
   latch_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (phase == rsl_pkg::RSL_CHECK && eval_rst) |=> !latch_out) // R3
      else $error("latch not low after reset");
   latch_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (phase == rsl_pkg::RSL_CHECK && eval_set && !eval_rst && !wdt_hit) |=> latch_out) // R1
      else $error("latch not high after set");
   latch_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (phase != rsl_pkg::RSL_CHECK && !wdt_hit) |=> $stable(latch_out)) // R14
      else $error("latch changed outside evaluation");
   wdt_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
      wdt_hit |=> (wdt_error && phase == rsl_pkg::RSL_IDLE && !latch_out)) // R12
      else $error("watchdog overrun not handled");
   scan_store_a: assert property (@(posedge aclk) disable iff (!aresetn)
      scan_done |-> (scan_cur == $past(scan_cnt) + 32'h0000_0001)) // R9
      else $error("scan time not stored");
   scan_max_a: assert property (@(posedge aclk) disable iff (!aresetn)
      scan_done |-> (scan_max >= scan_cur)) // R10
      else $error("maximum below current scan");
   sequence end_entry_s;
      phase == rsl_pkg::RSL_CHECK && !wdt_hit;
   endsequence
   end_phase_a: assert property (@(posedge aclk) disable iff (!aresetn)
      end_entry_s |=> (phase == rsl_pkg::RSL_END && !scan_done)) // R13
      else $error("housekeeping cut short");
   scan_order_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (phase == rsl_pkg::RSL_INPUT && !wdt_hit) |=> phase == rsl_pkg::RSL_EVAL) // R11
      else $error("evaluation out of order");
endmodule

// ==== testbench/rsl_io_model.sv ====
// Far-side model: program blocks and I/O driving the latch set and reset lines
`timescale 1ns/100ps
module rsl_io_model (
   input wire logic aclk,
   input wire logic want_set,
   input wire logic want_reset,
   output logic set_in,
   output logic reset_in
);
   // Levels change just after an edge, as an upstream block output would
   initial
   begin
      set_in = 1'b0;
      reset_in = 1'b0;
   end
   always @(posedge aclk)
   begin
      set_in <= want_set;
      reset_in <= want_reset;
   end
endmodule

// ==== testbench/rsl_scan_latch_tb.sv ====
// Self-checking bench for the scan latch block
`timescale 1ns/100ps
module rsl_scan_latch_tb;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic want_set = 1'b0;
   logic want_reset = 1'b0;
   logic set_in, reset_in, latch_out, scan_done, wdt_error, irq;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, resp;
   logic [31:0] d;
   logic [2:0] tbl [6] = '{3'b101, 3'b001, 3'b110, 3'b101, 3'b010, 3'b000};
   int n_mismatch = 0;
   int samples_checked = 0;
   int cyc;
   localparam int END_N = 8;

   always #4 aclk = ~aclk;

   rsl_io_model u_io (.aclk(aclk), .want_set(want_set), .want_reset(want_reset), .set_in(set_in),
      .reset_in(reset_in));

   rsl_scan_latch #(.END_CYCLES(END_N)) u_dut (.aclk(aclk), .aresetn(aresetn), .set_in(set_in),
      .reset_in(reset_in), .latch_out(latch_out), .scan_done(scan_done), .wdt_error(wdt_error), .irq(irq),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
      begin
         $display("STATUS OK");
      end
      else
      begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic hang();
      n_mismatch++;
      $display("mismatch wait expected answer seen none");
      tally_and_finish();
   endtask

   // Valid and payload held until each ready; bready held until bvalid
   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
      int i;
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 50; i++)
      begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid)
         begin
            r = bresp;
            bready <= 1'b0;
            break;
         end
      end
      if (i == 50) hang();
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
      int i;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (i = 0; i < 50; i++)
      begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid)
         begin
            v = rdata;
            r = rresp;
            rready <= 1'b0;
            break;
         end
      end
      if (i == 50) hang();
   endtask

   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      rd(a, d, resp);
      chk(nm, e, d);
      chk("rresp", {30'h0, rsl_pkg::AXI_OKAY}, {30'h0, resp});
   endtask

   // Waits for n end-of-scan pulses, then counts cycles to the next one
   task automatic scans(input int n);
      int i;
      for (i = 0; i < 300 && n > 0; i++)
      begin
         @(posedge aclk);
         if (scan_done === 1'b1) n--;
      end
      if (n > 0) hang();
      for (cyc = 1; cyc < 300; cyc++)
      begin
         @(posedge aclk);
         if (scan_done === 1'b1) break;
      end
      if (cyc == 300) hang();
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      rchk("ctrl", rsl_pkg::ADDR_CTRL, 32'h0);
      rchk("mask", rsl_pkg::ADDR_IRQ_MASK, 32'h0);
      rchk("wdt_limit", rsl_pkg::ADDR_WDT_LIMIT, rsl_pkg::WDT_LIMIT_RESET);
      rd(8'h1C, d, resp);
      chk("unmapped rresp", {30'h0, rsl_pkg::AXI_SLVERR}, {30'h0, resp});
      wr(8'h1C, 32'hFFFF_FFFF, resp);
      chk("unmapped bresp", {30'h0, rsl_pkg::AXI_SLVERR}, {30'h0, resp});
      // Reset line left unconnected: set wins although reset is high
      wr(rsl_pkg::ADDR_CTRL, 32'h1, resp);
      want_set <= 1'b1;
      want_reset <= 1'b1;
      scans(3);
      chk("latch unconnected", 32'h1, {31'h0, latch_out});
      want_set <= 1'b0;
      want_reset <= 1'b0;
      wr(rsl_pkg::ADDR_CTRL, 32'h3, resp);
      scans(3);
      chk("latch keep", 32'h1, {31'h0, latch_out});
      for (int k = 0; k < 6; k++)
      begin
         want_set <= tbl[k][2];
         want_reset <= tbl[k][1];
         scans(3);
         chk("latch table", {31'h0, tbl[k][0]}, {31'h0, latch_out});
      end
      chk("scan period", 5 + END_N, cyc);
      rchk("scan_cur", rsl_pkg::ADDR_SCAN_CUR, 5 + END_N);
      rchk("scan_max", rsl_pkg::ADDR_SCAN_MAX, 5 + END_N);
      rd(rsl_pkg::ADDR_IRQ_STAT, d, resp);
      chk("stat done", 32'h1, d & 32'h1);
      wr(rsl_pkg::ADDR_IRQ_MASK, 32'h1, resp);
      repeat (3) @(posedge aclk);
      chk("irq done", 32'h1, {31'h0, irq});
      wr(rsl_pkg::ADDR_IRQ_MASK, 32'h2, resp);
      repeat (3) @(posedge aclk);
      chk("irq masked", 32'h0, {31'h0, irq});
      // Overrun: latch set first so the forced clear is visible
      want_set <= 1'b1;
      want_reset <= 1'b0;
      scans(3);
      wr(rsl_pkg::ADDR_WDT_LIMIT, 32'h5, resp);
      for (cyc = 0; cyc < 100 && wdt_error !== 1'b1; cyc++) @(posedge aclk);
      if (cyc == 100) hang();
      chk("latch wdt", 32'h0, {31'h0, latch_out});
      @(posedge aclk);
      @(posedge aclk);
      chk("irq wdt", 32'h1, {31'h0, irq});
      wr(rsl_pkg::ADDR_WDT_LIMIT, rsl_pkg::WDT_LIMIT_RESET, resp);
      wr(rsl_pkg::ADDR_CTRL, 32'h2, resp);
      repeat (30) @(posedge aclk);
      rchk("status idle", rsl_pkg::ADDR_STATUS, 32'h1);
      wr(rsl_pkg::ADDR_CTRL, 32'h6, resp);
      rchk("scan_max clear", rsl_pkg::ADDR_SCAN_MAX, 32'h0);
      wr(rsl_pkg::ADDR_IRQ_STAT, 32'h7, resp);
      rchk("stat cleared", rsl_pkg::ADDR_IRQ_STAT, 32'h0);
      chk("irq cleared", 32'h0, {31'h0, irq});
      wr(rsl_pkg::ADDR_CTRL, 32'h3, resp);
      scans(2);
      chk("wdt restart", 32'h0, {31'h0, wdt_error});
      chk("latch restart", 32'h1, {31'h0, latch_out});
      rchk("scan_max again", rsl_pkg::ADDR_SCAN_MAX, 5 + END_N);
      tally_and_finish();
   end
endmodule
